/* File: include/ccsow_pkg.sv */
/*
  Constants and carrier types for the CPU clock select and oscillator
  watchdog block: register offsets, field positions, reset values,
  boot codes and the watchdog overflow count.
  Assumes a 32-bit AHB-Lite register bus and one 200 MHz system clock.
*/
package ccsow_pkg;
  // ----------------------------------------------------------------
  // Register map, byte addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_SYSCFG = 8'h00; // System configuration
  localparam logic [7:0] OFF_STATUS = 8'h04; // Sticky events, read clears
  localparam logic [7:0] OFF_MASK = 8'h08; // Interrupt mask
  localparam logic [7:0] OFF_BUSCFG = 8'h0c; // Bus configuration fields
  localparam logic [7:0] OFF_TIMING = 8'h10; // Derived bus timing, read only
  localparam logic [7:0] OFF_CLKST = 8'h14; // Clock state, read only

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int WDDIS_BIT = 4; // Watchdog disable in system config
  localparam logic [31:0] SYSCFG_RST = 32'h0000_0000; // Watchdog on
  localparam logic [31:0] BUSCFG_RST = 32'h0000_0000;
  localparam int CLKST_FAIL_BIT = 4;
  localparam int CLKST_LOOP_BIT = 5;

  // ----------------------------------------------------------------
  // Clock options and timing figures
  // ----------------------------------------------------------------
  localparam logic [2:0] BOOT_PRESCALE = 3'h1; // Input divided by two
  localparam logic [2:0] BOOT_DIRECT = 3'h3; // Input drives directly
  localparam logic [4:0] WD_OVF = 5'h10; // Loop clocks to overflow
  localparam logic [7:0] LOOP_HALF = 8'h04; // Sys cycles per loop clock
  localparam logic [4:0] WAIT_BASE = 5'h0f; // Wait time base count
  localparam logic [1:0] TRI_BASE = 2'h1; // Tristate base count

  // ----------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] addr;
  } ccsow_aphase_t; // Latched AHB address phase

  typedef struct packed {
    logic [1:0] tri_hp; // Tristate, half periods
    logic [4:0] wait_hp; // Wait time, half periods
    logic [3:0] ext_hp; // Latch extension, half periods
  } ccsow_timing_t;
endpackage

/* File: design/ccsow_clock_ctrl.sv */
/*
  CPU clock selection, oscillator watchdog and bus timing derivation,
  with an AHB-Lite register slave and one level interrupt.
  Assumes the oscillator input and boot pins are synchronous to
  clock_in, and a single AHB master with whole-word single transfers.
*/
// Implementation choices: the placing of the registers and the AHB-Lite slave port.
// What this block does
// - Code 001 divides oscillator input by two
// - Divided half period equals one input period
// - Code 011 drives CPU clock directly
// - Direct clock follows input duty cycle
// - Watchdog enabled after reset, disable bit four
// - Watchdog only in direct or divided mode
// - Loop clocks count up, input transitions clear
// - Sixteen loop clocks without transition mean failure
// - Failure switches to loop clock, raises flag
// - Switched clock stays until hardware reset
// - Watchdog disabled: input clock, loop off
// - Bus timing derived from configuration fields
// - Three boot pins, other codes multiply
`timescale 1ns/1ps
module ccsow_clock_ctrl (
  input wire logic clock_in,
  input wire logic srst_in,
  input wire logic clock_input_pin_in, // Oscillator input level
  input wire logic [2:0] boot_clock_select_pins_in,
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  output logic [31:0] hrdata_out,
  output logic hreadyout_out,
  output logic hresp_out,
  output logic cpu_clk_out, // Generated CPU clock level
  output logic loop_enable_out, // Loop powered
  output logic osc_fail_irq_out // Level interrupt
);
  // ----------------------------------------------------------------
  // Decoding helper
  // ----------------------------------------------------------------
  // Word match on the low address byte
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a[7:2] == off[7:2]);
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  ccsow_pkg::ccsow_aphase_t ap_r, ap_nxt; // Pending data phase
  logic [31:0] system_config_register_r, system_config_register_nxt;
  logic [31:0] bus_config_regs_r, bus_config_regs_nxt;
  logic status_r, status_nxt; // Oscillator failure event
  logic mask_r, mask_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic irq_r, irq_nxt;
  logic [2:0] boot_r, boot_nxt; // Latched clock option
  logic pin_prev_r, pin_prev_nxt;
  logic [7:0] loop_cnt_r, loop_cnt_nxt;
  logic loop_en_r, loop_en_nxt;
  logic [4:0] wd_cnt_r, wd_cnt_nxt; // Watchdog counter
  logic failed_r, failed_nxt; // Switched to loop clock
  logic cpu_r, cpu_nxt;
  // Combinational helpers
  ccsow_pkg::ccsow_timing_t timing;
  logic pll_mode, wd_dis, wd_act, trans, rise, loop_tick, fail_evt;
  logic rd_take;

  // ----------------------------------------------------------------
  // Clock generation and watchdog
  // ----------------------------------------------------------------
  // Next values for clock option, loop, watchdog and CPU clock
  always_comb
  begin
    // Boot code is caught while reset is held
    boot_nxt = srst_in ? boot_clock_select_pins_in : boot_r;
    pll_mode = (boot_r != ccsow_pkg::BOOT_PRESCALE) &&
               (boot_r != ccsow_pkg::BOOT_DIRECT);
    wd_dis = system_config_register_r[ccsow_pkg::WDDIS_BIT];
    wd_act = !wd_dis && !pll_mode && !failed_r;
    pin_prev_nxt = clock_input_pin_in;
    trans = clock_input_pin_in != pin_prev_r;
    rise = clock_input_pin_in && !pin_prev_r;
    // Free-running loop modelled as a divider of the system clock
    loop_tick = loop_en_r && (loop_cnt_r == ccsow_pkg::LOOP_HALF - 8'h01);
    if (!loop_en_r || loop_tick)
    begin
      loop_cnt_nxt = 8'h00;
    end
    else
    begin
      loop_cnt_nxt = loop_cnt_r + 8'h01;
    end
    // Transition clears, loop clock counts
    if (!wd_act || trans)
    begin
      wd_cnt_nxt = 5'h00;
    end
    else if (loop_tick)
    begin
      wd_cnt_nxt = wd_cnt_r + 5'h01;
    end
    else
    begin
      wd_cnt_nxt = wd_cnt_r;
    end
    // Overflow on the sixteenth loop clock without a transition
    fail_evt = wd_act && !trans && loop_tick &&
               (wd_cnt_r == ccsow_pkg::WD_OVF - 5'h01);
    failed_nxt = failed_r || fail_evt;
    // Loop stays powered whenever it may be the clock source
    loop_en_nxt = pll_mode || failed_nxt ||
                  !system_config_register_nxt[ccsow_pkg::WDDIS_BIT];
    // Loop-sourced clocks only change on a loop edge, so no runt pulse
    if (failed_r || pll_mode)
    begin
      cpu_nxt = loop_tick ? !cpu_r : cpu_r;
    end
    else if (boot_r == ccsow_pkg::BOOT_PRESCALE)
    begin
      cpu_nxt = rise ? !cpu_r : cpu_r;
    end
    else
    begin
      cpu_nxt = clock_input_pin_in;
    end
  end

  // Register the clock state
  always_ff @(posedge clock_in)
  begin
    boot_r <= boot_nxt;
    pin_prev_r <= pin_prev_nxt;
    if (srst_in)
    begin
      loop_cnt_r <= 8'h00;
      loop_en_r <= 1'b1;
      wd_cnt_r <= 5'h00;
      failed_r <= 1'b0;
      cpu_r <= 1'b0;
    end
    else
    begin
      loop_cnt_r <= loop_cnt_nxt;
      loop_en_r <= loop_en_nxt;
      wd_cnt_r <= wd_cnt_nxt;
      failed_r <= failed_nxt;
      cpu_r <= cpu_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Register slave
  // ----------------------------------------------------------------
  // Address phase capture, writes, read mux and status
  always_comb
  begin
    rd_take = hsel_in && htrans_in[1] && hready_in && !hwrite_in;
    ap_nxt.valid = hsel_in && htrans_in[1] && hready_in;
    ap_nxt.write = hwrite_in;
    ap_nxt.addr = haddr_in[7:0];
    system_config_register_nxt = system_config_register_r;
    bus_config_regs_nxt = bus_config_regs_r;
    mask_nxt = mask_r;
    // Writes land at the end of the data phase
    if (ap_r.valid && ap_r.write)
    begin
      if (hit(ap_r.addr, ccsow_pkg::OFF_SYSCFG))
      begin
        system_config_register_nxt = hwdata_in;
      end
      if (hit(ap_r.addr, ccsow_pkg::OFF_BUSCFG))
      begin
        bus_config_regs_nxt = hwdata_in;
      end
      if (hit(ap_r.addr, ccsow_pkg::OFF_MASK))
      begin
        mask_nxt = hwdata_in[0];
      end
    end
    // Derived bus cycle additions in half CPU periods
    timing.ext_hp = {3'h0, bus_config_regs_r[0]};
    timing.wait_hp = 5'((ccsow_pkg::WAIT_BASE - {1'b0, bus_config_regs_r[7:4]}) << 1);
    timing.tri_hp = 2'((ccsow_pkg::TRI_BASE - {1'b0, bus_config_regs_r[8]}) << 1);
    // Read clears, a same-cycle event still wins
    status_nxt = (rd_take && hit(haddr_in[7:0], ccsow_pkg::OFF_STATUS)) ? 1'b0 : status_r;
    status_nxt = status_nxt || fail_evt;
    irq_nxt = status_nxt && mask_nxt;
    // Read data for the coming data phase; unmapped reads give zero
    rdata_nxt = rdata_r;
    if (rd_take)
    begin
      rdata_nxt = 32'h0000_0000;
      if (hit(haddr_in[7:0], ccsow_pkg::OFF_SYSCFG))
      begin
        rdata_nxt = system_config_register_nxt;
      end
      if (hit(haddr_in[7:0], ccsow_pkg::OFF_STATUS))
      begin
        rdata_nxt = {31'h0, status_r};
      end
      if (hit(haddr_in[7:0], ccsow_pkg::OFF_MASK))
      begin
        rdata_nxt = {31'h0, mask_nxt};
      end
      if (hit(haddr_in[7:0], ccsow_pkg::OFF_BUSCFG))
      begin
        rdata_nxt = bus_config_regs_nxt;
      end
      if (hit(haddr_in[7:0], ccsow_pkg::OFF_TIMING))
      begin
        rdata_nxt = {14'h0, timing.tri_hp, 3'h0, timing.wait_hp, 4'h0, timing.ext_hp};
      end
      if (hit(haddr_in[7:0], ccsow_pkg::OFF_CLKST))
      begin
        rdata_nxt = {26'h0, loop_en_r, failed_r, 1'b0, boot_r};
      end
    end
  end

  // Register the bus state
  always_ff @(posedge clock_in)
  begin
    if (srst_in)
    begin
      ap_r <= '0;
      system_config_register_r <= ccsow_pkg::SYSCFG_RST;
      bus_config_regs_r <= ccsow_pkg::BUSCFG_RST;
      status_r <= 1'b0;
      mask_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      irq_r <= 1'b0;
    end
    else
    begin
      ap_r <= ap_nxt;
      system_config_register_r <= system_config_register_nxt;
      bus_config_regs_r <= bus_config_regs_nxt;
      status_r <= status_nxt;
      mask_r <= mask_nxt;
      rdata_r <= rdata_nxt;
      irq_r <= irq_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Zero-wait slave, always OKAY
  always_ff @(posedge clock_in)
  begin
    hreadyout_out <= 1'b1;
    hresp_out <= 1'b0;
  end
  assign hrdata_out = rdata_r;
  assign cpu_clk_out = cpu_r;
  assign loop_enable_out = loop_en_r;
  assign osc_fail_irq_out = irq_r;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (srst_in);

  chk_fail_sticky: assert property (failed_r |=> failed_r)
    else $error("clock source left loop after failure");
  chk_wd_overflow: assert property (wd_act && !trans && loop_tick &&
    wd_cnt_r == 5'h0f |=> failed_r && status_r)
    else $error("watchdog overflow not taken as failure");
  chk_trans_clear: assert property (trans |=> wd_cnt_r == 5'h00)
    else $error("input transition did not clear watchdog");
  chk_no_early_fail: assert property (!failed_r && wd_cnt_r < 5'h0f |=> !failed_r)
    else $error("failure declared before overflow");
  chk_direct_follow: assert property (!failed_r && boot_r == 3'h3 && !srst_in
    |=> cpu_clk_out == $past(clock_input_pin_in))
    else $error("direct clock does not follow input");
  chk_prescale_edge: assert property (!failed_r && boot_r == 3'h1 && rise
    |=> cpu_clk_out != $past(cpu_clk_out))
    else $error("divided clock missed an input rise");
  chk_prescale_hold: assert property (!failed_r && boot_r == 3'h1 && !rise
    |=> $stable(cpu_clk_out))
    else $error("divided clock moved without input rise");
  chk_fail_glitch: assert property (failed_r && !loop_tick |=> $stable(cpu_clk_out))
    else $error("loop clock changed off a loop edge");
  // Checked in the same cycle: a later write may legally power the loop again
  chk_loop_off: assert property (wd_dis && !pll_mode && !failed_r &&
    $stable(system_config_register_r) |-> !loop_enable_out)
    else $error("loop powered with watchdog disabled");
  // Multiplying modes never arm the watchdog, so they can never fail over
  chk_pll_no_wd: assert property (pll_mode |=> wd_cnt_r == 5'h00 && !failed_r)
    else $error("watchdog counted while loop multiplies");
  chk_fail_switch: assert property (fail_evt |=> failed_r && loop_enable_out)
    else $error("failure did not switch to powered loop clock");
  chk_irq_level: assert property (osc_fail_irq_out == (status_r && mask_r))
    else $error("interrupt level disagrees with status and mask");
  chk_reset_enable: assert property ($past(srst_in) |-> !wd_dis)
    else $error("watchdog not enabled after reset");
endmodule

/* File: sim/ccsow_osc_model.sv */
/*
  Behavioural oscillator that drives the clock input pin.
  Assumes it is stepped by the 200 MHz clock_in; it can be stopped.
*/
`timescale 1ns/1ps
module ccsow_osc_model (
  input wire logic clock_in,
  input wire logic run_in, // Oscillates while high
  input wire logic [3:0] high_in, // High phase, clock_in cycles
  input wire logic [3:0] low_in, // Low phase, clock_in cycles
  output logic osc_out // Pin level
);
  logic [3:0] cnt_r = 4'h1; // Cycles spent in this phase
  initial osc_out = 1'b0;
  // ----------------------------------------------------------------
  // Phase generator
  // ----------------------------------------------------------------
  // A stopped crystal sticks at its last level, the worst case for a detector
  always @(posedge clock_in)
  begin
    if (run_in)
    begin
      if (cnt_r >= (osc_out ? high_in : low_in))
      begin
        osc_out <= ~osc_out;
        cnt_r <= 4'h1;
      end
      else
        cnt_r <= cnt_r + 4'h1;
    end
  end
endmodule

/* File: sim/tb.sv */
/*
  Self-checking bench for the clock select and oscillator watchdog.
  Assumes the design header and package as delivered, one clock.
*/
`timescale 1ns/1ps
module tb;
  logic clock_in = 1'b0;
  logic srst = 1'b1;
  logic [2:0] boot = 3'h3;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic run = 1'b1; // Oscillator running
  logic [3:0] hi = 4'h2;
  logic [3:0] lo = 4'h3;
  logic osc, cpu_clk, loop_en, irq, hready, hresp;
  logic [31:0] hrdata, rd, b;
  logic [2:0] codes [6] = '{3'h0, 3'h2, 3'h4, 3'h5, 3'h6, 3'h7}; // Loop codes
  int failures = 0;
  int n_tests = 0;
  int seed = 16;
  int n, m;
  always #2.5 clock_in = ~clock_in;
  ccsow_osc_model osc_m (.clock_in(clock_in), .run_in(run), .high_in(hi), .low_in(lo),
    .osc_out(osc));
  ccsow_clock_ctrl uut (.clock_in(clock_in), .srst_in(srst), .clock_input_pin_in(osc),
    .boot_clock_select_pins_in(boot), .hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans),
    .hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata), .hready_in(hready),
    .hrdata_out(hrdata), .hreadyout_out(hready), .hresp_out(hresp), .cpu_clk_out(cpu_clk),
    .loop_enable_out(loop_en), .osc_fail_irq_out(irq));
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    begin
      n_tests++;
      if (got !== exp)
      begin
        failures++;
        $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
    end
  endtask
  // One AHB single word transfer; read data lands in rd
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int k;
    begin
      k = 0;
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {24'h0, a};
      hwrite <= wr;
      @(posedge clock_in);
      while (hready !== 1'b1 && k < 50)
      begin
        @(posedge clock_in);
        k++;
      end
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      @(posedge clock_in);
      while (hready !== 1'b1 && k < 100)
      begin
        @(posedge clock_in);
        k++;
      end
      if (hready !== 1'b1)
      begin
        failures++;
        $display("ERROR %0t bus wait ran out", $time);
      end
      rd = hrdata;
      chk({31'h0, hresp}, 32'h0);
    end
  endtask
  task automatic boot_reset(input logic [2:0] code);
    begin
      srst <= 1'b1;
      boot <= code;
      repeat (10) @(posedge clock_in);
      srst <= 1'b0;
      @(posedge clock_in);
    end
  endtask
  // Cycles until the CPU clock next changes, bounded
  task automatic gap(output int t);
    logic p;
    begin
      t = 0;
      p = cpu_clk;
      while (cpu_clk === p && t < 50)
      begin
        @(posedge clock_in);
        #1;
        t++;
      end
    end
  endtask
  // CPU clock changes seen over a span of cycles
  task automatic toggles(input int cyc, output int t);
    logic p;
    begin
      t = 0;
      p = cpu_clk;
      repeat (cyc)
      begin
        @(posedge clock_in);
        #1;
        if (cpu_clk !== p)
          t++;
        p = cpu_clk;
      end
    end
  endtask
  // Expected derived timing word, in half periods
  function automatic logic [31:0] timing_exp(input logic [31:0] c);
    logic [31:0] t;
    begin
      t = 32'h0;
      t[3:0] = {3'h0, c[0]};
      t[12:8] = 5'h1e - {c[7:4], 1'b0};
      t[17:16] = c[8] ? 2'h0 : 2'h2;
      timing_exp = t;
    end
  endfunction
  task automatic stop_test;
    begin
      $display("Comparisons %0d, mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0)
        $display("ALL CHECKS OK");
      else
        $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  // ----------------------------------------------------------------
  // Watchdog against hangs, well beyond the expected run
  // ----------------------------------------------------------------
  initial
  begin
    #200000;
    failures++;
    stop_test();
  end
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    boot_reset(3'h3);
    bus(0, ccsow_pkg::OFF_SYSCFG, 32'h0);
    chk(rd, ccsow_pkg::SYSCFG_RST);
    bus(0, ccsow_pkg::OFF_CLKST, 32'h0);
    chk(rd, 32'h23);
    gap(n);
    gap(n);
    gap(m);
    chk(n + m, 5);
    chk(n * m, 6);
    for (int i = 0; i < 6; i++)
    begin
      // Corners first: all fields low, then all fields high
      b = (i == 0) ? 32'h0 : (i == 1) ? 32'h1f1 : $random(seed);
      bus(1, ccsow_pkg::OFF_BUSCFG, b);
      bus(0, ccsow_pkg::OFF_TIMING, 32'h0);
      chk(rd, timing_exp(b));
    end
    bus(1, 8'h20, 32'hffffffff);
    bus(0, 8'h20, 32'h0);
    chk(rd, 32'h0);
    bus(1, ccsow_pkg::OFF_MASK, 32'h1);
    gap(n);
    run <= 1'b0;
    n = 0;
    while (irq !== 1'b1 && n < 200)
    begin
      @(posedge clock_in);
      #1;
      n++;
    end
    chk({31'h0, n >= 61 && n <= 64}, 32'h1);
    bus(0, ccsow_pkg::OFF_CLKST, 32'h0);
    chk(rd, 32'h33);
    toggles(40, n);
    chk(n, 10);
    run <= 1'b1;
    toggles(40, n);
    chk(n, 10);
    bus(1, ccsow_pkg::OFF_MASK, 32'h0);
    repeat (2) @(posedge clock_in);
    chk({31'h0, irq}, 32'h0);
    bus(1, ccsow_pkg::OFF_MASK, 32'h1);
    repeat (2) @(posedge clock_in);
    chk({31'h0, irq}, 32'h1);
    bus(0, ccsow_pkg::OFF_STATUS, 32'h0);
    chk(rd, 32'h1);
    bus(0, ccsow_pkg::OFF_STATUS, 32'h0);
    chk(rd, 32'h0);
    chk({31'h0, irq}, 32'h0);
    boot_reset(3'h1);
    hi <= 4'h2;
    lo <= 4'h5;
    bus(0, ccsow_pkg::OFF_CLKST, 32'h0);
    chk(rd, 32'h21);
    gap(n);
    repeat (3)
    begin
      gap(n);
      chk(n, 7);
    end
    bus(1, ccsow_pkg::OFF_SYSCFG, 32'h10);
    repeat (2) @(posedge clock_in);
    chk({31'h0, loop_en}, 32'h0);
    run <= 1'b0;
    repeat (120) @(posedge clock_in);
    bus(0, ccsow_pkg::OFF_STATUS, 32'h0);
    chk(rd, 32'h0);
    run <= 1'b1;
    foreach (codes[i])
    begin
      boot_reset(codes[i]);
      run <= 1'b0;
      // Long enough for sixteen loop clocks, so an armed watchdog would trip
      toggles(80, n);
      chk(n, 20);
      bus(0, ccsow_pkg::OFF_CLKST, 32'h0);
      chk(rd, 32'h20 | {29'h0, codes[i]});
      run <= 1'b1;
    end
    stop_test();
  end
endmodule
